/* hw/ergt_pkg.sv */
// ergt_pkg: constants and carrier types for the external reference gain trim
// assumes one clock domain and single-cycle register write strobes
package ergt_pkg;

  localparam int REG_WIDTH   = 16;
  localparam int FIELD_WIDTH = 11;
  localparam int PAD_WIDTH   = REG_WIDTH - FIELD_WIDTH;

  // trim register layout
  localparam int TRIM_FIELD_MSB = 10;
  localparam int TRIM_FIELD_LSB = 0;
  localparam logic [FIELD_WIDTH-1:0] TRIM_FIELD_RESET = 11'h3fa;
  localparam logic [REG_WIDTH-1:0]   TRIM_REG_RESET   = 16'h03fa;
  localparam logic [PAD_WIDTH-1:0]   TRIM_PAD_ZERO    = 5'h00;

  // secondary configuration layout
  localparam int EXTERNAL_REFERENCE_SELECT_SEL_BIT = 3;
  localparam logic EXTERNAL_REFERENCE_SELECT_SEL_RESET = 1'b0;

  // gain factor codes
  localparam logic [REG_WIDTH-1:0] GAIN_BASE    = 16'ha6d0;
  localparam logic [REG_WIDTH-1:0] GAIN_DEFAULT = 16'haaca;
  localparam logic [REG_WIDTH-1:0] GAIN_MAX     = 16'haecf;
  localparam logic [REG_WIDTH-1:0] GAIN_MIN     = 16'ha6d0;

  typedef struct packed {
    logic                 wr;
    logic [REG_WIDTH-1:0] data;
  } ergt_reg_write_type;

endpackage : ergt_pkg

/* hw/ergt_gain_sum.sv */
// ergt_gain_sum: forms final gain factor and the gain that is applied
// assumes field and select are already the values to be registered
`timescale 1ns/100ps
module ergt_gain_sum
  import ergt_pkg::*;
(
  input  wire logic [FIELD_WIDTH-1:0] trim_field,
  input  wire logic                   ext_sel,
  input  wire logic [REG_WIDTH-1:0]   internal_gain,
  output logic      [REG_WIDTH-1:0]   final_gain,
  output logic      [REG_WIDTH-1:0]   applied_gain
);

  always_comb begin
    final_gain = GAIN_BASE + {TRIM_PAD_ZERO, trim_field};
    if (ext_sel) begin
      applied_gain = final_gain;
    end else begin
      applied_gain = internal_gain;
    end
  end

endmodule : ergt_gain_sum

/* hw/ergt_top.sv */
// ergt_top: gain trim register, reference select bit and gain output
// assumes write strobes are one-cycle pulses synchronous to clk
`timescale 1ns/100ps
module ergt_top
  import ergt_pkg::*;
#(
  parameter logic [REG_WIDTH-1:0] INTERNAL_GAIN = GAIN_DEFAULT
)
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire ergt_reg_write_type trim_write,
  input  wire ergt_reg_write_type config_write,
  output logic [REG_WIDTH-1:0]    trim_rdata,
  output logic                    external_reference_select,
  output logic [REG_WIDTH-1:0]    final_gain_factor,
  output logic [REG_WIDTH-1:0]    applied_gain
);

  logic [FIELD_WIDTH-1:0] gain_trim_field;
  logic [FIELD_WIDTH-1:0] next_gain_trim_field;
  logic [REG_WIDTH-1:0]   next_trim_rdata;
  logic                   next_external_reference_select;
  logic [REG_WIDTH-1:0]   next_final_gain_factor;
  logic [REG_WIDTH-1:0]   next_applied_gain;

  // read view of a trim field, pad bits forced low
  function automatic logic [REG_WIDTH-1:0] trim_reg_view(
    input logic [FIELD_WIDTH-1:0] field
  );
    return {TRIM_PAD_ZERO, field};
  endfunction : trim_reg_view

  // field part of a written word, upper bits dropped
  function automatic logic [FIELD_WIDTH-1:0] trim_field_of(
    input logic [REG_WIDTH-1:0] word
  );
    return word[TRIM_FIELD_MSB:TRIM_FIELD_LSB];
  endfunction : trim_field_of

  // gain code for a trim field, for the checks
  function automatic logic [REG_WIDTH-1:0] gain_of(
    input logic [FIELD_WIDTH-1:0] field
  );
    return GAIN_BASE + trim_reg_view(field);
  endfunction : gain_of

  // trim register group
  always_comb begin
    next_gain_trim_field = gain_trim_field;
    if (trim_write.wr) begin
      next_gain_trim_field = trim_field_of(trim_write.data);
    end
    next_trim_rdata = trim_reg_view(next_gain_trim_field);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_trim_field <= TRIM_FIELD_RESET;
      trim_rdata      <= TRIM_REG_RESET;
    end else begin
      gain_trim_field <= next_gain_trim_field;
      trim_rdata      <= next_trim_rdata;
    end
  end

  // reference select group
  always_comb begin
    next_external_reference_select = external_reference_select;
    if (config_write.wr) begin
      next_external_reference_select =
        config_write.data[EXTERNAL_REFERENCE_SELECT_SEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      external_reference_select <= EXTERNAL_REFERENCE_SELECT_SEL_RESET;
    end else begin
      external_reference_select <= next_external_reference_select;
    end
  end

  // gain group: sums use the values being registered, so gains
  // move in the same cycle as the register they derive from
  ergt_gain_sum u_gain_sum (
    .trim_field    (next_gain_trim_field),
    .ext_sel       (next_external_reference_select),
    .internal_gain (INTERNAL_GAIN),
    .final_gain    (next_final_gain_factor),
    .applied_gain  (next_applied_gain)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      final_gain_factor <= GAIN_DEFAULT;
      applied_gain      <= INTERNAL_GAIN;
    end else begin
      final_gain_factor <= next_final_gain_factor;
      applied_gain      <= next_applied_gain;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_trim_upper_zero: assert property (
    trim_rdata[REG_WIDTH-1:FIELD_WIDTH] == TRIM_PAD_ZERO)
    else $error("trim upper bits not zero");

  chk_trim_reset_value: assert property (
    @(posedge clk) disable iff (1'b0)
    !rst_n |=> (trim_rdata == TRIM_REG_RESET)
      && (final_gain_factor == GAIN_DEFAULT))
    else $error("trim reset value wrong");

  chk_trim_write_load: assert property (
    rst_n && trim_write.wr |=> trim_rdata ==
      trim_reg_view(trim_field_of($past(trim_write.data))))
    else $error("trim write not loaded");

  chk_trim_hold_value: assert property (
    rst_n && !trim_write.wr |=> $stable(trim_rdata))
    else $error("trim changed without write");

  chk_int_ref_gain: assert property (
    !external_reference_select |-> applied_gain == INTERNAL_GAIN)
    else $error("trim affected internal gain");

  chk_external_reference_select_gain: assert property (
    external_reference_select |-> applied_gain == final_gain_factor)
    else $error("external gain not applied");

  chk_final_gain_sum: assert property (
    final_gain_factor ==
      GAIN_BASE + {TRIM_PAD_ZERO, trim_rdata[TRIM_FIELD_MSB:0]})
    else $error("final gain sum wrong");

  chk_default_gain_val: assert property (
    trim_rdata == TRIM_REG_RESET |-> final_gain_factor == GAIN_DEFAULT)
    else $error("default gain wrong");

  chk_gain_range_ok: assert property (
    final_gain_factor >= GAIN_MIN && final_gain_factor <= GAIN_MAX)
    else $error("gain out of range");

  chk_select_write: assert property (
    rst_n && config_write.wr |=>
      external_reference_select == $past(config_write.data[EXTERNAL_REFERENCE_SELECT_SEL_BIT]))
    else $error("select bit not loaded");

  chk_field_view_match: assert property (
    trim_rdata == trim_reg_view(gain_trim_field))
    else $error("trim field and read view differ");

  chk_field_reset_value: assert property (
    @(posedge clk) disable iff (1'b0)
    !rst_n |=> gain_trim_field == TRIM_FIELD_RESET)
    else $error("trim field reset value wrong");

  chk_select_reset_value: assert property (
    @(posedge clk) disable iff (1'b0)
    !rst_n |=> !external_reference_select
      && (applied_gain == INTERNAL_GAIN))
    else $error("select or applied gain reset wrong");

  chk_select_hold_value: assert property (
    rst_n && !config_write.wr |=> $stable(external_reference_select))
    else $error("select changed without write");

  chk_final_hold_value: assert property (
    rst_n && !trim_write.wr |=> $stable(final_gain_factor))
    else $error("final gain changed without write");

  chk_int_ref_steady: assert property (
    rst_n && !config_write.wr && !external_reference_select
      |=> $stable(applied_gain))
    else $error("trim write moved internal gain");

  chk_gain_max_code: assert property (
    trim_rdata == trim_reg_view({FIELD_WIDTH{1'b1}})
      |-> final_gain_factor == GAIN_MAX)
    else $error("all-ones trim not max gain");

  chk_gain_min_code: assert property (
    trim_rdata == trim_reg_view({FIELD_WIDTH{1'b0}})
      |-> final_gain_factor == GAIN_MIN)
    else $error("all-zeros trim not min gain");

  chk_dual_write_gain: assert property (
    rst_n && trim_write.wr && config_write.wr
      && config_write.data[EXTERNAL_REFERENCE_SELECT_SEL_BIT]
      |=> applied_gain == gain_of(trim_field_of($past(trim_write.data))))
    else $error("joint write gain wrong");

  chk_trim_write_ext: assert property (
    rst_n && trim_write.wr && external_reference_select
      && !config_write.wr
      |=> applied_gain == gain_of(trim_field_of($past(trim_write.data))))
    else $error("trim write not applied under external ref");

  chk_applied_range_ok: assert property (
    external_reference_select
      |-> applied_gain >= GAIN_MIN && applied_gain <= GAIN_MAX)
    else $error("applied gain out of range");

  chk_select_drop_other: assert property (
    rst_n && config_write.wr && !config_write.data[EXTERNAL_REFERENCE_SELECT_SEL_BIT]
      |=> !external_reference_select)
    else $error("select set without its bit");

  chk_pad_write_drop: assert property (
    rst_n && trim_write.wr
      && (trim_write.data[REG_WIDTH-1:FIELD_WIDTH] != TRIM_PAD_ZERO)
      |=> trim_rdata[REG_WIDTH-1:FIELD_WIDTH] == TRIM_PAD_ZERO)
    else $error("trim pad bits kept a write");

  cov_external_reference_select_on: cover property (
    !external_reference_select ##1 external_reference_select);
  cov_gain_max: cover property (final_gain_factor == GAIN_MAX);
  cov_gain_min: cover property (final_gain_factor == GAIN_MIN);
  cov_default_ext: cover property (
    external_reference_select && trim_rdata == TRIM_REG_RESET);
  cov_trim_under_ext: cover property (
    external_reference_select && trim_write.wr);

endmodule : ergt_top

/* verif/testbench.sv */
// testbench: random and corner writes to the gain trim block, self-checked
// assumes ergt_pkg and ergt_top are compiled first
`timescale 1ns/100ps
module testbench;
  import ergt_pkg::*;
  logic                   clk;
  logic                   rst_n;
  ergt_reg_write_type     tw;
  ergt_reg_write_type     cw;
  logic [REG_WIDTH-1:0]   rd;
  logic [REG_WIDTH-1:0]   fg;
  logic [REG_WIDTH-1:0]   ag;
  logic                   sel;
  logic [31:0]            lf;
  logic [FIELD_WIDTH-1:0] et;
  logic                   es;
  int                     num_errors;
  int                     n_tests;

  ergt_top dut (
    .clk                       (clk),
    .rst_n                     (rst_n),
    .trim_write                (tw),
    .config_write              (cw),
    .trim_rdata                (rd),
    .external_reference_select (sel),
    .final_gain_factor         (fg),
    .applied_gain              (ag)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] exp_final(input logic [10:0] f);
    return 16'ha6d0 + {5'h00, f};
  endfunction : exp_final

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize;
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // compare every output against the bench's own model
  task automatic check_all;
    @(negedge clk);
    chk("trim_rdata", rd, {5'h00, et});
    chk("final_gain", fg, exp_final(et));
    chk("select", {15'h0000, sel}, {15'h0000, es});
    chk("applied", ag, es ? exp_final(et) : 16'haaca);
  endtask : check_all

  task automatic wr(logic tv, logic [15:0] td, logic cv, logic [15:0] cd);
    @(posedge clk);
    tw <= '{tv, td};
    cw <= '{cv, cd};
    if (tv) et = td[10:0];
    if (cv) es = cd[3];
    @(posedge clk);
    tw.wr <= 1'b0;
    cw.wr <= 1'b0;
    check_all();
  endtask : wr

  task automatic do_reset(int n);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
    et = 11'h3fa;
    es = 1'b0;
    @(negedge clk);
    chk("reset_rdata", rd, 16'h03fa);
    chk("reset_final", fg, 16'haaca);
    check_all();
  endtask : do_reset

  initial begin
    rst_n = 1'b0;
    tw = '0;
    cw = '0;
    num_errors = 0;
    n_tests = 0;
    lf = 32'hfdd1;
    do_reset(4);
    wr(1'b1, 16'hffff, 1'b1, 16'h0008);
    chk("max_gain", fg, 16'haecf);
    wr(1'b1, 16'hf800, 1'b0, 16'h0000);
    chk("min_gain", fg, 16'ha6d0);
    wr(1'b0, 16'h0000, 1'b1, 16'hfff7);
    wr(1'b1, 16'h0123, 1'b1, 16'h0008);
    for (int i = 0; i < 60; i++) begin
      lf = lfsr(lf);
      wr(lf[0], lf[31:16], lf[1], lf[15:0]);
    end
    do_reset(1);
    summarize();
  end
endmodule : testbench
